// File: core/rsc_pkg.sv
// ----------------------------------------------------------------
// Reset source controller shared definitions
// ----------------------------------------------------------------
package rsc_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets on the plain register port)
    // ------------------------------------------------------------
    localparam logic [7:0] RSC_ADDR_CAUSE_FLAGS = 8'h00;
    localparam logic [7:0] RSC_ADDR_SOFT_TRIGGER = 8'h01;

    // ------------------------------------------------------------
    // Cause flag bit positions
    // ------------------------------------------------------------
    localparam int RSC_BIT_POWERUP = 0;
    localparam int RSC_BIT_UNDERVOLT = 1;
    localparam int RSC_BIT_PIN = 2;
    localparam int RSC_BIT_WATCHDOG = 3;
    localparam int RSC_BIT_SOFT = 4;
    localparam int RSC_BIT_DEBUG_PORT = 5;
    localparam int RSC_NUM_FLAGS = 6;
    localparam int RSC_BIT_SOFT_REQ = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] RSC_FLAGS_AFTER_POWERUP = 6'h01;
    localparam logic [7:0] RSC_SOFT_TRIGGER_READ = 8'h00;
    localparam logic [7:0] RSC_RDATA_IDLE = 8'h00;

    // ------------------------------------------------------------
    // Timing: figures as printed, cycle counts derived from clock
    // ------------------------------------------------------------
    localparam int RSC_CLK_MHZ = 100;
    localparam int RSC_INIT_TIME_US = 250;
    localparam int RSC_SCAN_TIME_PER_KB_US = 500;
    localparam int RSC_STARTUP_STEP_US = 1000;
    localparam int RSC_INIT_CYCLES = RSC_INIT_TIME_US * RSC_CLK_MHZ;
    localparam int RSC_SCAN_CYCLES_PER_KB = RSC_SCAN_TIME_PER_KB_US * RSC_CLK_MHZ;
    localparam int RSC_STARTUP_STEP_CYCLES = RSC_STARTUP_STEP_US * RSC_CLK_MHZ;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsc_bus_req_type;

    typedef struct packed {
        logic all_logic;
        logic debug_port;
        logic retained_cfg;
    } rsc_scope_type;

    typedef enum logic [1:0] {
        RSC_ST_RUN,
        RSC_ST_HOLD,
        RSC_ST_RELOAD,
        RSC_ST_INIT
    } rsc_state_type;

endpackage : rsc_pkg

// File: core/rsc_reset_source_controller.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module rsc_reset_source_controller #(
    parameter int unsigned INIT_CYCLES = rsc_pkg::RSC_INIT_CYCLES,
    parameter int unsigned SCAN_CYCLES_PER_KB = rsc_pkg::RSC_SCAN_CYCLES_PER_KB,
    parameter int unsigned STARTUP_STEP_CYCLES = rsc_pkg::RSC_STARTUP_STEP_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire rsc_pkg::rsc_bus_req_type bus_req,
    output logic [7:0] bus_rdata,
    input wire logic powerup_detect,
    input wire logic supply_dip_detect,
    input wire logic reset_pin_n,
    input wire logic pin_reset_fuse_en,
    input wire logic watchdog_expired,
    input wire logic debug_port_reset_req,
    input wire logic debug_port_external,
    input wire logic io_unlock_open,
    input wire logic [2:0] startup_delay_fuse,
    input wire logic [1:0] boot_checksum_source,
    input wire logic [3:0] checksum_kbytes,
    output rsc_pkg::rsc_scope_type reset_scope,
    output logic override_disable,
    output logic fuse_reload,
    output logic boot_done
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (INIT_CYCLES < 1) begin : g_bad_init
        $error("INIT_CYCLES must be at least one");
    end
    if (SCAN_CYCLES_PER_KB < 1 || STARTUP_STEP_CYCLES < 1) begin : g_bad_step
        $error("Scan and start-up step counts must be at least one");
    end

    // Longest init, top fuse codes, must fit the 32-bit countdown
    if (64'(INIT_CYCLES) + 64'(3'h7) * 64'(STARTUP_STEP_CYCLES) + 64'(4'hF) * 64'(SCAN_CYCLES_PER_KB)
        > 64'h0000_0000_FFFF_FFFF) begin : g_bad_total
        $error("Longest init time overflows the countdown");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Sequencer state
    rsc_pkg::rsc_state_type state_q;
    rsc_pkg::rsc_state_type state_d;

    // Cause flags and their set and clear terms
    logic [5:0] flags_q;
    logic [5:0] flags_d;
    logic [5:0] flag_set;
    logic [5:0] flag_clr;

    // One-cycle requests held until the hold phase
    logic soft_pend_q;
    logic wdt_pend_q;

    // Scope accumulators, widest source wins
    logic scope_power_q;
    logic scope_dip_q;
    logic scope_user_q;
    logic scope_debug_q;

    // Boot marker, countdown and registered outputs
    logic boot_done_q;
    logic [31:0] init_cnt_q;
    logic [31:0] init_total;
    logic [7:0] rdata_q;
    rsc_pkg::rsc_scope_type scope_q;
    logic override_disable_q;
    logic fuse_reload_q;

    // Decoded bus and source terms
    logic cpu_running;
    logic wr_flags;
    logic wr_soft;
    logic soft_fire;
    logic src_pin;
    logic src_debug;
    logic any_active;

    // ------------------------------------------------------------
    // Source qualification
    // ------------------------------------------------------------

    // Register writes only count while the CPU is out of reset
    assign cpu_running = (state_q == rsc_pkg::RSC_ST_RUN);
    assign wr_flags = bus_req.wr && cpu_running && (bus_req.addr == rsc_pkg::RSC_ADDR_CAUSE_FLAGS);
    assign wr_soft = bus_req.wr && cpu_running && (bus_req.addr == rsc_pkg::RSC_ADDR_SOFT_TRIGGER);

    // Unlock window judged in the write cycle itself
    // trigger on write one
    assign soft_fire = wr_soft && io_unlock_open && bus_req.wdata[rsc_pkg::RSC_BIT_SOFT_REQ];

    assign src_pin = pin_reset_fuse_en && !reset_pin_n;

    assign src_debug = debug_port_reset_req && debug_port_external;

    // level sources hold the first phase
    assign any_active = powerup_detect || supply_dip_detect || src_pin || src_debug
        || soft_pend_q || wdt_pend_q || soft_fire || watchdog_expired;

    // ------------------------------------------------------------
    // Pending latches for one-cycle requests
    // ------------------------------------------------------------

    // Pulses are held until the sequence reaches the hold phase,
    // so a short request still keeps the device in reset.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            soft_pend_q <= 1'b0;
        end else if (soft_fire) begin
            soft_pend_q <= 1'b1;
        end else if (state_q == rsc_pkg::RSC_ST_HOLD) begin
            soft_pend_q <= 1'b0;
        end
    end

    // A level expiry re-arms the latch until it drops
    // watchdog expiry latched as a request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wdt_pend_q <= 1'b0;
        end else if (watchdog_expired) begin
            wdt_pend_q <= 1'b1;
        end else if (state_q == rsc_pkg::RSC_ST_HOLD) begin
            wdt_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------

    // Worst case fits 32 bits; checked at elaboration
    // base time plus start-up fuse delay
    // scan adds a fixed time per kilobyte
    always_comb begin
        init_total = 32'(INIT_CYCLES) + 32'(startup_delay_fuse) * 32'(STARTUP_STEP_CYCLES);
        if (boot_checksum_source != 2'b00) begin
            init_total = init_total + 32'(checksum_kbytes) * 32'(SCAN_CYCLES_PER_KB);
        end
    end

    // Next state: hold while any source is active, then reload, then init
    // A request during reload or init restarts the sequence
    // no sleep gating anywhere in the sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rsc_pkg::RSC_ST_RUN: begin
                if (any_active) begin
                    state_d = rsc_pkg::RSC_ST_HOLD;
                end
            end
            rsc_pkg::RSC_ST_HOLD: begin
                if (!any_active) begin
                    state_d = rsc_pkg::RSC_ST_RELOAD;
                end
            end
            rsc_pkg::RSC_ST_RELOAD: begin
                state_d = any_active ? rsc_pkg::RSC_ST_HOLD : rsc_pkg::RSC_ST_INIT;
            end
            rsc_pkg::RSC_ST_INIT: begin
                if (any_active) begin
                    state_d = rsc_pkg::RSC_ST_HOLD;
                end else if (init_cnt_q <= 32'h0000_0001) begin
                    state_d = rsc_pkg::RSC_ST_RUN;
                end
            end
        endcase
    end

    // release taken on a clock edge only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= rsc_pkg::RSC_ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Init countdown, loaded as the fuses are reloaded
    // Loading in the reload cycle picks up the fresh fuse values
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            init_cnt_q <= 32'h0000_0000;
        end else if (state_q == rsc_pkg::RSC_ST_RELOAD) begin
            init_cnt_q <= init_total;
        end else if (state_q == rsc_pkg::RSC_ST_INIT && init_cnt_q != 32'h0000_0000) begin
            init_cnt_q <= init_cnt_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fuse_reload_q <= 1'b0;
        end else begin
            fuse_reload_q <= (state_d == rsc_pkg::RSC_ST_RELOAD);
        end
    end

    // ------------------------------------------------------------
    // Reset scope tracking
    // ------------------------------------------------------------

    // Scopes accumulate over one sequence; the widest source wins.
    // Cleared only when the device returns to running.
    // Trade-off: a late narrower source never shrinks the scope.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scope_power_q <= 1'b1;
            scope_dip_q <= 1'b0;
            scope_user_q <= 1'b0;
            scope_debug_q <= 1'b0;
        end else if (state_d == rsc_pkg::RSC_ST_RUN) begin
            scope_power_q <= 1'b0;
            scope_dip_q <= 1'b0;
            scope_user_q <= 1'b0;
            scope_debug_q <= 1'b0;
        end else begin
            scope_power_q <= scope_power_q | powerup_detect;
            scope_dip_q <= scope_dip_q | supply_dip_detect;
            scope_user_q <= scope_user_q | src_pin | soft_fire | watchdog_expired;
            scope_debug_q <= scope_debug_q | src_debug;
        end
    end

    // Scope outputs registered from the next state and scope terms
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scope_q <= '{all_logic: 1'b1, debug_port: 1'b1, retained_cfg: 1'b1};
        end else begin
            // user sources spare the debug port
            scope_q.all_logic <= (state_d != rsc_pkg::RSC_ST_RUN);
            scope_q.debug_port <= (state_d != rsc_pkg::RSC_ST_RUN)
                && (scope_power_q || scope_dip_q || powerup_detect || supply_dip_detect);
            scope_q.retained_cfg <= (state_d != rsc_pkg::RSC_ST_RUN) && (scope_power_q || powerup_detect);
        end
    end

    // One cycle of lag behind the detector; no memory needed
    // override off while power-on asserted
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            override_disable_q <= 1'b1;
        end else begin
            override_disable_q <= powerup_detect;
        end
    end

    // Full boot marker; gates non-power flags after a power-on
    // rst counts as a power-on, so the marker starts low
    // cleared by power-on, set at boot end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            boot_done_q <= 1'b0;
        end else if (powerup_detect) begin
            boot_done_q <= 1'b0;
        end else if (state_q == rsc_pkg::RSC_ST_INIT && state_d == rsc_pkg::RSC_ST_RUN) begin
            boot_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------

    // Set terms per source; a set in the clear cycle wins
    always_comb begin
        flag_set = 6'h00;
        // each source marks its own bit
        flag_set[rsc_pkg::RSC_BIT_POWERUP] = powerup_detect;
        if (boot_done_q) begin
            flag_set[rsc_pkg::RSC_BIT_UNDERVOLT] = supply_dip_detect;
            flag_set[rsc_pkg::RSC_BIT_PIN] = src_pin;
            flag_set[rsc_pkg::RSC_BIT_WATCHDOG] = watchdog_expired;
            flag_set[rsc_pkg::RSC_BIT_SOFT] = soft_fire;
            flag_set[rsc_pkg::RSC_BIT_DEBUG_PORT] = src_debug;
        end
    end

    // Bits 7:6 are not stored, so their write data is dropped
    // write one clears, zero keeps
    // upper bits dropped from the write
    assign flag_clr = wr_flags ? bus_req.wdata[5:0] : 6'h00;

    always_comb begin
        // only software clears the power-on flag
        flags_d = (flags_q & ~flag_clr) | flag_set;
        // Power-on overrides a clear in the same cycle
        // power-on forces the others to zero
        if (powerup_detect) begin
            flags_d = rsc_pkg::RSC_FLAGS_AFTER_POWERUP;
        end
    end

    // Flags survive every reset except power-on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_q <= rsc_pkg::RSC_FLAGS_AFTER_POWERUP;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= rsc_pkg::RSC_RDATA_IDLE;
        end else if (bus_req.rd && bus_req.addr == rsc_pkg::RSC_ADDR_CAUSE_FLAGS) begin
            rdata_q <= {2'b00, flags_q};
        end else if (bus_req.rd && bus_req.addr == rsc_pkg::RSC_ADDR_SOFT_TRIGGER) begin
            rdata_q <= rsc_pkg::RSC_SOFT_TRIGGER_READ;
        end else begin
            rdata_q <= rsc_pkg::RSC_RDATA_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output leaves straight from a flip-flop
    assign bus_rdata = rdata_q;
    assign reset_scope = scope_q;
    assign override_disable = override_disable_q;
    assign fuse_reload = fuse_reload_q;
    assign boot_done = boot_done_q;

endmodule : rsc_reset_source_controller

// File: sim/rsc_sva.sv
`timescale 1ns/10ps
// ----------
// Port checks
// ----------
module rsc_sva #(
    parameter int unsigned INIT_CYCLES = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire rsc_pkg::rsc_bus_req_type bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic powerup_detect,
    input wire logic supply_dip_detect,
    input wire logic reset_pin_n,
    input wire logic pin_reset_fuse_en,
    input wire logic watchdog_expired,
    input wire logic debug_port_reset_req,
    input wire logic debug_port_external,
    input wire logic io_unlock_open,
    input wire rsc_pkg::rsc_scope_type reset_scope,
    input wire logic override_disable,
    input wire logic fuse_reload,
    input wire logic boot_done
);
    logic quiet;
    // No source other than the bus asks for reset
    assign quiet = !powerup_detect && !supply_dip_detect && !(pin_reset_fuse_en && !reset_pin_n)
        && !watchdog_expired && !(debug_port_reset_req && debug_port_external);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    trig_read_a: assert property (bus_req.rd && bus_req.addr == 8'h01
        |=> bus_rdata == 8'h00) else $error("trigger read nonzero");
    por_scope_a: assert property (powerup_detect |=> reset_scope == 3'b111)
        else $error("power-on scope wrong");
    override_off_a: assert property (powerup_detect |=> override_disable)
        else $error("override left available");
    pin_req_a: assert property (pin_reset_fuse_en && !reset_pin_n |=> reset_scope.all_logic)
        else $error("pin low without reset");
    dip_scope_a: assert property (supply_dip_detect && !powerup_detect && !reset_scope.retained_cfg
        |=> reset_scope.debug_port && !reset_scope.retained_cfg) else $error("dip scope wrong");
    user_scope_a: assert property ((watchdog_expired || debug_port_reset_req && debug_port_external)
        && !supply_dip_detect && !powerup_detect && !reset_scope.debug_port
        |=> reset_scope.all_logic && !reset_scope.debug_port) else $error("user scope wrong");
    soft_go_a: assert property (bus_req.wr && bus_req.addr == 8'h01 && bus_req.wdata[0]
        && io_unlock_open && !reset_scope.all_logic |=> reset_scope.all_logic) else $error("soft reset missed");
    locked_a: assert property (quiet && bus_req.wr && bus_req.addr == 8'h01 && !io_unlock_open
        && !reset_scope.all_logic |=> !reset_scope.all_logic) else $error("locked write reset");
    debug_gate_a: assert property (quiet && debug_port_reset_req && !bus_req.wr
        && !reset_scope.all_logic |=> !reset_scope.all_logic) else $error("debug request not gated");
    reload_init_a: assert property (fuse_reload |=> reset_scope.all_logic [*8])
        else $error("init too short");
    boot_end_a: assert property ($rose(boot_done) |-> $fell(reset_scope.all_logic))
        else $error("boot end mismatch");
    cover property (fuse_reload && reset_scope.debug_port);
    cover property ($rose(boot_done));
    cover property (bus_req.wr && bus_req.addr == 8'h01 && io_unlock_open);
endmodule : rsc_sva

bind rsc_reset_source_controller rsc_sva #(.INIT_CYCLES(INIT_CYCLES)) rsc_sva_inst (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .powerup_detect(powerup_detect),
    .supply_dip_detect(supply_dip_detect), .reset_pin_n(reset_pin_n), .pin_reset_fuse_en(pin_reset_fuse_en),
    .watchdog_expired(watchdog_expired), .debug_port_reset_req(debug_port_reset_req),
    .debug_port_external(debug_port_external), .io_unlock_open(io_unlock_open), .reset_scope(reset_scope),
    .override_disable(override_disable), .fuse_reload(fuse_reload), .boot_done(boot_done));

// File: sim/rsc_source_model.sv
`timescale 1ns/10ps
// ----------
// Reset source stand-ins
// ----------
module rsc_source_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] fire_kind,
    input wire logic [7:0] fire_len,
    output logic powerup_detect,
    output logic supply_dip_detect,
    output logic reset_pin_n,
    output logic watchdog_expired,
    output logic debug_port_reset_req
);
    logic [2:0] kind_q;
    logic [7:0] left_q;
    logic on;
    // Latch a request, then count its length down
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            kind_q <= 3'h0;
            left_q <= 8'h00;
        end else if (fire_kind != 3'h0) begin
            kind_q <= fire_kind;
            left_q <= fire_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    assign on = left_q != 8'h00;
    assign powerup_detect = on && kind_q == 3'h1;
    assign supply_dip_detect = on && kind_q == 3'h2;
    assign reset_pin_n = !(on && kind_q == 3'h3);
    assign watchdog_expired = on && kind_q == 3'h4;
    assign debug_port_reset_req = on && kind_q == 3'h5;
endmodule : rsc_source_model

// File: sim/tb.sv
`timescale 1ns/10ps
`define RSC_CHK(nm, e, g) \
    samples_checked++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end
module tb;
    localparam int INIT = 8;
    localparam int SCAN = 4;
    localparam int STEP = 2;
    logic mclk, rst, powerup_detect, supply_dip_detect, reset_pin_n, watchdog_expired, debug_port_reset_req;
    logic pin_reset_fuse_en, debug_port_external, io_unlock_open, override_disable, fuse_reload, boot_done;
    rsc_pkg::rsc_bus_req_type bus_req;
    rsc_pkg::rsc_scope_type reset_scope;
    logic [7:0] bus_rdata, exp_d, fire_len, flags_e;
    logic [2:0] startup_delay_fuse, fire_kind;
    logic [1:0] boot_checksum_source;
    logic [3:0] checksum_kbytes;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [2:0] kinds[5] = '{3'h3, 3'h4, 3'h6, 3'h5, 3'h2};
    logic [2:0] scopes[5] = '{3'b100, 3'b100, 3'b100, 3'b100, 3'b110};
    int bits[5] = '{2, 3, 4, 5, 1};
    int num_errors = 0;
    int samples_checked = 0;

    rsc_reset_source_controller #(.INIT_CYCLES(INIT), .SCAN_CYCLES_PER_KB(SCAN), .STARTUP_STEP_CYCLES(STEP))
    rsc_reset_source_controller_inst (.mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .powerup_detect(powerup_detect), .supply_dip_detect(supply_dip_detect), .reset_pin_n(reset_pin_n),
        .pin_reset_fuse_en(pin_reset_fuse_en), .watchdog_expired(watchdog_expired),
        .debug_port_reset_req(debug_port_reset_req), .debug_port_external(debug_port_external),
        .io_unlock_open(io_unlock_open), .startup_delay_fuse(startup_delay_fuse),
        .boot_checksum_source(boot_checksum_source), .checksum_kbytes(checksum_kbytes),
        .reset_scope(reset_scope), .override_disable(override_disable), .fuse_reload(fuse_reload),
        .boot_done(boot_done));
    rsc_source_model rsc_source_model_inst (.mclk(mclk), .rst(rst), .fire_kind(fire_kind), .fire_len(fire_len),
        .powerup_detect(powerup_detect), .supply_dip_detect(supply_dip_detect), .reset_pin_n(reset_pin_n),
        .watchdog_expired(watchdog_expired), .debug_port_reset_req(debug_port_reset_req));

    // ----------
    // Bus and source drivers
    // ----------
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask : bus_write
    task automatic bus_read(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
    endtask : bus_read
    task automatic fire(input logic [2:0] k, input logic [7:0] len);
        @(posedge mclk);
        fire_kind <= k;
        fire_len <= len;
        @(posedge mclk);
        fire_kind <= 3'h0;
    endtask : fire
    task automatic fuse_pick();
        startup_delay_fuse <= 3'($urandom_range(7));
        boot_checksum_source <= 2'($urandom_range(3));
        checksum_kbytes <= 4'($urandom_range(15));
    endtask : fuse_pick
    // Follows one reset to its end; the init length depends on the fuses
    task automatic await_boot(input logic [2:0] scope_e);
        int n;
        int tot;
        tot = INIT + STEP * int'(startup_delay_fuse);
        if (boot_checksum_source != 2'h0) begin
            tot = tot + SCAN * int'(checksum_kbytes);
        end
        for (n = 0; n < 400 && fuse_reload !== 1'b1; n++) @(negedge mclk);
        `RSC_CHK("scope", scope_e, reset_scope)
        for (n = 0; n < 400 && reset_scope.all_logic !== 1'b0; n++) @(negedge mclk);
        `RSC_CHK("init cycles", tot + 1, n)
        `RSC_CHK("boot done", 1'b1, boot_done)
    endtask : await_boot
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Read data stands only in the cycle after the strobe
    always @(posedge mclk) rd_seen <= bus_req.rd;
    always @(negedge mclk) begin
        if (rd_seen) begin
            exp_d = exp_q.pop_front();
            `RSC_CHK("read data", exp_d, bus_rdata)
        end
    end
    // Hang guard, well past the longest run
    initial begin
        repeat (4000) @(posedge mclk);
        num_errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        bus_req = '0;
        fire_kind = 3'h0;
        fire_len = 8'h00;
        pin_reset_fuse_en = 1'b0;
        debug_port_external = 1'b0;
        io_unlock_open = 1'b0;
        void'($urandom(61));
        fuse_pick();
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        await_boot(3'b111);
        bus_read(8'h00, 8'h01);
        bus_write(8'h00, 8'h00);
        bus_read(8'h00, 8'h01);
        bus_write(8'h00, 8'h01);
        bus_read(8'h00, 8'h00);
        // Locked trigger, unqualified debugger, pin without its fuse
        bus_write(8'h01, 8'h01);
        fire(3'h5, 8'h03);
        fire(3'h3, 8'h03);
        repeat (6) @(negedge mclk);
        `RSC_CHK("refused reset", 1'b0, reset_scope.all_logic)
        @(posedge mclk);
        pin_reset_fuse_en <= 1'b1;
        debug_port_external <= 1'b1;
        io_unlock_open <= 1'b1;
        flags_e = 8'h00;
        for (int i = 0; i < 5; i++) begin
            fuse_pick();
            if (kinds[i] == 3'h6) begin
                bus_write(8'h01, 8'hFF);
            end else begin
                fire(kinds[i], 8'(1 + $urandom_range(6)));
            end
            flags_e[bits[i]] = 1'b1;
            await_boot(scopes[i]);
            bus_read(8'h00, flags_e);
        end
        io_unlock_open <= 1'b0;
        bus_write(8'h00, 8'hFF);
        bus_read(8'h00, 8'h00);
        bus_read(8'h07, 8'h00);
        bus_read(8'h01, 8'h00);
        // Supply loss, then a pin request while still booting
        fire(3'h1, 8'h14);
        repeat (2) @(posedge mclk);
        bus_read(8'h00, 8'h01);
        @(negedge mclk);
        `RSC_CHK("override off", 1'b1, override_disable)
        `RSC_CHK("boot flag", 1'b0, boot_done)
        repeat (16) @(posedge mclk);
        fire(3'h3, 8'h02);
        for (int n = 0; n < 400 && reset_scope.all_logic !== 1'b0; n++) @(negedge mclk);
        `RSC_CHK("final boot", 1'b1, boot_done)
        bus_read(8'h00, 8'h01);
        repeat (2) @(posedge mclk);
        print_verdict();
    end
endmodule : tb
